// ### design/fscr_defs.vh
`ifndef FSCR_DEFS_VH
`define FSCR_DEFS_VH

// ****************************************
// command opcodes
// ****************************************
`define FSCR_OP_WRITE_REGS     8'h01
`define FSCR_OP_READ_SECOND    8'h07
`define FSCR_OP_READ_ANY       8'h65
`define FSCR_OP_WRITE_ANY      8'h71

// ****************************************
// any-register addresses
// ****************************************
`define FSCR_ADDR_SR1_NV       8'h00
`define FSCR_ADDR_CR1_NV       8'h02
`define FSCR_ADDR_SR1_V        8'h10
`define FSCR_ADDR_SR2_V        8'h11
`define FSCR_ADDR_CR1_V        8'h12

// ****************************************
// field positions
// ****************************************
`define FSCR_SR2_ERASE_DONE    2
`define FSCR_SR2_ERASE_SUSP    1
`define FSCR_SR2_PROG_SUSP     0
`define FSCR_CR1_PROT_ORIGIN   5
`define FSCR_CR1_PROT_VOLAT    3
`define FSCR_CR1_PARAM_LOC     2
`define FSCR_CR1_FOUR_LANE     1
`define FSCR_CR1_FREEZE        0
`define FSCR_SR1_BP_HI         4
`define FSCR_SR1_BP_LO         2

// ****************************************
// reset and shipped values
// ****************************************
`define FSCR_SR2_RESET         8'h00
`define FSCR_OTP_SHIPPED       3'h0
`define FSCR_NONVOLATILE_BLOCK_PROTECT_BITS_SHIPPED     3'h0
`define FSCR_BP_ALL_ONES       3'h7
`define FSCR_FOUR_LANE_SHIPPED 1'b0
`define FSCR_FREEZE_DEFAULT    1'b0

// ****************************************
// timing
// ****************************************
`define FSCR_CLK_MHZ           20
`define FSCR_T_NV_WRITE_US     500
`define FSCR_T_VOL_WRITE_NS    50

`endif

// ### design/fscr_otp_field.v
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// one-time-programmable field: bits only ever go from 0 to 1
// ****************************************
module fscr_otp_field #(
	parameter       WIDTH = 3,
	parameter [WIDTH-1:0] SHIPPED = {WIDTH{1'b0}}
) (
	input  wire             i_clock,
	input  wire             i_resetn,
	input  wire             i_write,
	input  wire [WIDTH-1:0] i_data,
	output reg  [WIDTH-1:0] o_q
);

	// a zero written over a programmed one is simply dropped
	always @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_q <= SHIPPED;
		end else if (i_write) begin
			o_q <= o_q | i_data;
		end
	end

endmodule

`default_nettype wire

// ### design/fscr_regs.v
// Functional notes
// - second status readable by both read commands
// - bit 2 reports last erase-verify result
// - erase result unreliable while suspended
// - bit 1 shows erase-suspend, not writable
// - bit 0 shows program-suspend, not writable
// - config written by both writes, read by any-read
// - origin bit selects top or bottom protection
// - programmed one-time bits ignore zero, no error
// - selector zero: write programs nonvolatile protect slowly
// - selector one forces nonvolatile protect to 111
// - selector one: write updates volatile protect fast
// - location bit puts parameter sectors top or bottom
// - uniform map: location bit has no effect
// - origin and location bits set independently
// - four-lane default seeds volatile four-lane bit
// - nonvolatile four-lane protocol sets four-lane default
// - four-lane default not clearable while protocol active
// - freeze default seeds freeze, host cannot program
// - freeze silently blocks protection, fails one-time program
`timescale 1ns/10ps
`default_nettype none
`include "fscr_defs.vh"

module fscr_regs #(
	parameter NV_WRITE_CYCLES  = `FSCR_T_NV_WRITE_US * `FSCR_CLK_MHZ,
	parameter VOL_WRITE_CYCLES =
		(`FSCR_T_VOL_WRITE_NS * `FSCR_CLK_MHZ + 999) / 1000,
	parameter CNT_W            = 16
) (
	input  wire        I_CLOCK,
	input  wire        I_RESETN,
	input  wire        I_CMD_VALID,
	input  wire [7:0]  I_CMD_OPCODE,
	input  wire [7:0]  I_CMD_ADDR,
	input  wire [15:0] I_CMD_WDATA,
	input  wire        I_CMD_TWO_BYTES,
	input  wire        I_WRITE_ENABLE,
	input  wire        I_ERASE_SUSPEND,
	input  wire        I_PROGRAM_SUSPEND,
	input  wire        I_VERIFY_DONE,
	input  wire        I_VERIFY_PASS,
	input  wire        I_QPI_ACTIVE,
	input  wire        I_QPI_NV_PROGRAMMED,
	input  wire        I_SOFT_RESET,
	input  wire        I_OTP_PROGRAM_REQ,
	input  wire        I_UNIFORM_SECTORS,
	output reg  [7:0]  O_RDATA,
	output reg         O_RVALID,
	output reg         O_BUSY,
	output reg         O_WRITE_DONE,
	output reg         O_PROGRAM_ERROR,
	output reg         O_PROT_ORIGIN,
	output reg         O_PROT_VOLATILE,
	output reg  [2:0]  O_BLOCK_PROTECT,
	output reg         O_PARAM_LOCATION,
	output reg         O_FOUR_LANE,
	output reg         O_FREEZE
);

	localparam [CNT_W-1:0] NV_CNT  = NV_WRITE_CYCLES[CNT_W-1:0];
	localparam [CNT_W-1:0] VOL_CNT = VOL_WRITE_CYCLES[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
	localparam [7:0]       SR2_RESET_VAL = `FSCR_SR2_RESET;

	// ****************************************
	// state
	// ****************************************
	reg             load_pending;
	reg  [CNT_W-1:0] busy_cnt;
	reg  [CNT_W-1:0] next_busy_cnt;
	reg             erase_complete_flag;
	reg             erase_suspend_flag;
	reg             program_suspend_flag;
	reg  [2:0]      nonvolatile_block_protect_bits;
	reg  [2:0]      volatile_block_protect;
	reg             four_lane_default_bit;
	reg             volatile_four_lane;
	reg             freeze;
	reg  [7:0]      next_rdata;
	wire [2:0]      otp_bits;

	wire protection_origin_bit       = otp_bits[2];
	wire protect_volatility_selector = otp_bits[1];
	wire parameter_location_bit      = otp_bits[0];
	// not user programmable: fixed default, never written
	wire freeze_default_bit          = `FSCR_FREEZE_DEFAULT;

	// ****************************************
	// command decode
	// ****************************************
	wire is_write_regs = I_CMD_OPCODE == `FSCR_OP_WRITE_REGS;
	wire is_write_any  = I_CMD_OPCODE == `FSCR_OP_WRITE_ANY;
	wire is_read_any   = I_CMD_OPCODE == `FSCR_OP_READ_ANY;
	wire is_read_sec   = I_CMD_OPCODE == `FSCR_OP_READ_SECOND;

	// writes need the enable latch and an idle register file
	wire accept_write = I_CMD_VALID && !load_pending
		&& busy_cnt == CNT_ZERO && I_WRITE_ENABLE
		&& (is_write_regs || is_write_any);

	wire [7:0] first_byte  = I_CMD_WDATA[7:0];
	wire [7:0] second_byte = I_CMD_WDATA[15:8];

	// nonvolatile config byte: second data byte of a 16-cycle write-registers, first data byte of a write-any
	wire nonvolatile_protection_config_write = accept_write && ((is_write_regs && I_CMD_TWO_BYTES)
		|| (is_write_any && I_CMD_ADDR == `FSCR_ADDR_CR1_NV));
	wire [7:0] nonvolatile_protection_config_byte = is_write_regs ? second_byte : first_byte;
	wire volatile_protection_config_write = accept_write && is_write_any
		&& I_CMD_ADDR == `FSCR_ADDR_CR1_V;

	// protect bits: write-registers always carries them
	wire bp_from_wrr = accept_write && is_write_regs;
	wire nonvolatile_block_protect_bits_any   = accept_write && is_write_any
		&& I_CMD_ADDR == `FSCR_ADDR_SR1_NV;
	wire bp_v_any    = accept_write && is_write_any
		&& I_CMD_ADDR == `FSCR_ADDR_SR1_V;
	wire [2:0] bp_data = first_byte[`FSCR_SR1_BP_HI:`FSCR_SR1_BP_LO];

	// freeze locks these silently; no error status is raised
	wire nonvolatile_block_protect_bits_write = !freeze && !protect_volatility_selector
		&& (bp_from_wrr || nonvolatile_block_protect_bits_any);
	wire bp_v_write  = !freeze && (bp_from_wrr || bp_v_any
		|| nonvolatile_block_protect_bits_write);

	// only the defined one-time bits reach the field; others dropped
	wire       otp_write = nonvolatile_protection_config_write && !freeze;
	wire [2:0] otp_data  = {nonvolatile_protection_config_byte[`FSCR_CR1_PROT_ORIGIN],
		nonvolatile_protection_config_byte[`FSCR_CR1_PROT_VOLAT],
		nonvolatile_protection_config_byte[`FSCR_CR1_PARAM_LOC]};
	wire selector_rising = otp_write && otp_data[1]
		&& !protect_volatility_selector;

	// nonvolatile cells take the long write time
	wire slow_write = nonvolatile_protection_config_write || nonvolatile_block_protect_bits_write;

	// byte that lands on the four-lane bits, if any
	wire       four_lane_write = nonvolatile_protection_config_write || volatile_protection_config_write;
	wire [7:0] four_lane_byte  = nonvolatile_protection_config_write ? nonvolatile_protection_config_byte : first_byte;
	// a clear is refused while the four-lane protocol runs
	wire four_lane_value = four_lane_byte[`FSCR_CR1_FOUR_LANE]
		|| I_QPI_ACTIVE;

	// ****************************************
	// one-time-programmable bits
	// ****************************************
	fscr_otp_field #(
		.WIDTH   (3),
		.SHIPPED (`FSCR_OTP_SHIPPED)
	) u_otp (
		.i_clock  (I_CLOCK),
		.i_resetn (I_RESETN),
		.i_write  (otp_write),
		.i_data   (otp_data),
		.o_q      (otp_bits)
	);

	// ****************************************
	// nonvolatile protect and four-lane default
	// ****************************************
	// storage is modelled in flops; reset restores the shipped state
	always @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			nonvolatile_block_protect_bits <= `FSCR_NONVOLATILE_BLOCK_PROTECT_BITS_SHIPPED;
			four_lane_default_bit          <= `FSCR_FOUR_LANE_SHIPPED;
		end else begin
			if (selector_rising) begin
				nonvolatile_block_protect_bits <= `FSCR_BP_ALL_ONES;
			end else if (nonvolatile_block_protect_bits_write) begin
				nonvolatile_block_protect_bits <= bp_data;
			end
			if (I_QPI_NV_PROGRAMMED) begin
				four_lane_default_bit <= 1'b1;
			end else if (nonvolatile_protection_config_write) begin
				four_lane_default_bit <= four_lane_value;
			end
		end
	end

	// ****************************************
	// volatile copies
	// ****************************************
	// defaults are copied one cycle after reset release, since an
	// async reset may only load constants
	always @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			load_pending           <= 1'b1;
			volatile_block_protect <= `FSCR_NONVOLATILE_BLOCK_PROTECT_BITS_SHIPPED;
			volatile_four_lane     <= `FSCR_FOUR_LANE_SHIPPED;
			freeze                 <= `FSCR_FREEZE_DEFAULT;
		end else begin
			load_pending <= 1'b0;
			if (load_pending) begin
				volatile_block_protect <= nonvolatile_block_protect_bits;
				volatile_four_lane     <= four_lane_default_bit;
				freeze                 <= freeze_default_bit;
			end else if (I_SOFT_RESET) begin
				// command reset leaves freeze alone
				volatile_block_protect <= nonvolatile_block_protect_bits;
				volatile_four_lane     <= four_lane_default_bit;
			end else begin
				if (selector_rising) begin
					volatile_block_protect <= `FSCR_BP_ALL_ONES;
				end else if (bp_v_write) begin
					volatile_block_protect <= bp_data;
				end
				if (I_QPI_NV_PROGRAMMED) begin
					volatile_four_lane <= 1'b1;
				end else if (four_lane_write) begin
					volatile_four_lane <= four_lane_value;
				end
				// freeze can only be set; power cycle or pin reset clears
				if (four_lane_write
					&& four_lane_byte[`FSCR_CR1_FREEZE]) begin
					freeze <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// write timing
	// ****************************************
	always @* begin
		next_busy_cnt = busy_cnt;
		if (accept_write) begin
			next_busy_cnt = slow_write ? NV_CNT : VOL_CNT;
		end else if (busy_cnt != CNT_ZERO) begin
			next_busy_cnt = busy_cnt - CNT_ONE;
		end
	end

	always @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			busy_cnt     <= CNT_ZERO;
			O_BUSY       <= 1'b0;
			O_WRITE_DONE <= 1'b0;
		end else begin
			busy_cnt     <= next_busy_cnt;
			O_BUSY       <= next_busy_cnt != CNT_ZERO;
			O_WRITE_DONE <= busy_cnt == CNT_ONE && !accept_write;
		end
	end

	// ****************************************
	// second status register
	// ****************************************
	// suspend inputs come from the same clock domain: no synchroniser
	always @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			erase_complete_flag  <= SR2_RESET_VAL[`FSCR_SR2_ERASE_DONE];
			erase_suspend_flag   <= SR2_RESET_VAL[`FSCR_SR2_ERASE_SUSP];
			program_suspend_flag <= SR2_RESET_VAL[`FSCR_SR2_PROG_SUSP];
		end else begin
			// held across a suspend; the host must not trust it then
			if (I_VERIFY_DONE) begin
				erase_complete_flag <= I_VERIFY_PASS;
			end
			erase_suspend_flag   <= I_ERASE_SUSPEND;
			program_suspend_flag <= I_PROGRAM_SUSPEND;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	wire [7:0] sr2_value = {5'h00, erase_complete_flag,
		erase_suspend_flag, program_suspend_flag};
	wire [7:0] nonvolatile_protection_config_value = {2'h0, protection_origin_bit, 1'b0,
		protect_volatility_selector, parameter_location_bit,
		four_lane_default_bit, freeze_default_bit};
	wire [7:0] volatile_protection_config_value = {2'h0, protection_origin_bit, 1'b0,
		protect_volatility_selector, parameter_location_bit,
		volatile_four_lane, freeze};

	always @* begin
		next_rdata = 8'h00;
		if (is_read_sec) begin
			next_rdata = sr2_value;
		end else if (is_read_any) begin
			case (I_CMD_ADDR)
				`FSCR_ADDR_SR2_V: begin
					next_rdata = sr2_value;
				end
				`FSCR_ADDR_CR1_NV: begin
					next_rdata = nonvolatile_protection_config_value;
				end
				`FSCR_ADDR_CR1_V: begin
					next_rdata = volatile_protection_config_value;
				end
				`FSCR_ADDR_SR1_NV: begin
					next_rdata = {3'h0, nonvolatile_block_protect_bits, 2'h0};
				end
				`FSCR_ADDR_SR1_V: begin
					next_rdata = {3'h0, volatile_block_protect, 2'h0};
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	wire read_cmd = I_CMD_VALID && !load_pending
		&& (is_read_sec || is_read_any);

	always @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_RDATA  <= 8'h00;
			O_RVALID <= 1'b0;
		end else begin
			O_RVALID <= read_cmd;
			if (read_cmd) begin
				O_RDATA <= next_rdata;
			end
		end
	end

	// ****************************************
	// protection outputs
	// ****************************************
	always @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_PROGRAM_ERROR  <= 1'b0;
			O_PROT_ORIGIN    <= 1'b0;
			O_PROT_VOLATILE  <= 1'b0;
			O_BLOCK_PROTECT  <= 3'h0;
			O_PARAM_LOCATION <= 1'b0;
			O_FOUR_LANE      <= 1'b0;
			O_FREEZE         <= 1'b0;
		end else begin
			O_PROGRAM_ERROR  <= I_OTP_PROGRAM_REQ && freeze;
			O_PROT_ORIGIN    <= protection_origin_bit;
			O_PROT_VOLATILE  <= protect_volatility_selector;
			// selector picks which copy governs protection
			O_BLOCK_PROTECT  <= protect_volatility_selector
				? volatile_block_protect
				: nonvolatile_block_protect_bits;
			// uniform sectors: location bit means nothing
			O_PARAM_LOCATION <= parameter_location_bit
				&& !I_UNIFORM_SECTORS;
			O_FOUR_LANE      <= volatile_four_lane;
			O_FREEZE         <= freeze;
		end
	end

endmodule

`default_nettype wire

// ### sim/fscr_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks of the register bank
// ****
module fscr_regs_assertions #(
	parameter NV_WRITE_CYCLES  = 8,
	parameter VOL_WRITE_CYCLES = 1
) (
	input wire logic       I_CLOCK,
	input wire logic       I_RESETN,
	input wire logic       I_CMD_VALID,
	input wire logic [7:0] I_CMD_OPCODE,
	input wire logic       I_WRITE_ENABLE,
	input wire logic       I_ERASE_SUSPEND,
	input wire logic       I_PROGRAM_SUSPEND,
	input wire logic       I_SOFT_RESET,
	input wire logic       I_OTP_PROGRAM_REQ,
	input wire logic       I_UNIFORM_SECTORS,
	input wire logic [7:0] O_RDATA,
	input wire logic       O_RVALID,
	input wire logic       O_BUSY,
	input wire logic       O_WRITE_DONE,
	input wire logic       O_PROGRAM_ERROR,
	input wire logic       O_PROT_ORIGIN,
	input wire logic [2:0] O_BLOCK_PROTECT,
	input wire logic       O_PARAM_LOCATION,
	input wire logic       O_FREEZE
);
	logic [15:0] busy_len;
	wire logic   sr2_rd;
	wire logic   rd_op;
	assign sr2_rd = I_CMD_VALID && I_CMD_OPCODE == 8'h07;
	assign rd_op = sr2_rd || (I_CMD_VALID && I_CMD_OPCODE == 8'h65);
	// busy run length, judged at the falling edge of busy
	always @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN)
			busy_len <= 16'h0000;
		else if (O_BUSY)
			busy_len <= busy_len + 16'h0001;
		else
			busy_len <= 16'h0000;
	end
	default clocking dc @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESETN);
	property p_rd_lat;
		O_RVALID |-> $past(rd_op);
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("stray read valid");
	property p_sr2_susp;
		(sr2_rd && $stable(I_ERASE_SUSPEND) && $stable(I_PROGRAM_SUSPEND))
		|=> O_RDATA[1:0] == {$past(I_ERASE_SUSPEND), $past(I_PROGRAM_SUSPEND)};
	endproperty
	a_sr2_susp: assert property (p_sr2_susp) else $error("suspend bits");
	property p_sr2_rsv;
		sr2_rd |=> O_RDATA[7:3] == 5'h00;
	endproperty
	a_sr2_rsv: assert property (p_sr2_rsv) else $error("reserved bits");
	property p_frz_hold;
		O_FREEZE |=> O_FREEZE;
	endproperty
	a_frz_hold: assert property (p_frz_hold) else $error("freeze dropped");
	property p_frz_prot;
		(O_FREEZE && $past(O_FREEZE) && !$past(I_SOFT_RESET)
		&& !$past(I_SOFT_RESET, 2)) |-> $stable(O_BLOCK_PROTECT);
	endproperty
	a_frz_prot: assert property (p_frz_prot) else $error("frozen protect");
	property p_otp_err;
		(I_OTP_PROGRAM_REQ && O_FREEZE) |-> ##[1:2] O_PROGRAM_ERROR;
	endproperty
	a_otp_err: assert property (p_otp_err) else $error("no program error");
	property p_origin;
		O_PROT_ORIGIN |=> O_PROT_ORIGIN;
	endproperty
	a_origin: assert property (p_origin) else $error("origin cleared");
	property p_uniform;
		($past(I_UNIFORM_SECTORS) && $past(I_UNIFORM_SECTORS, 2))
		|-> !O_PARAM_LOCATION;
	endproperty
	a_uniform: assert property (p_uniform) else $error("location in uniform");
	property p_no_we;
		(I_CMD_VALID && !I_WRITE_ENABLE && !O_BUSY) |=> !O_BUSY;
	endproperty
	a_no_we: assert property (p_no_we) else $error("write without enable");
	property p_wr_len;
		$fell(O_BUSY) |-> O_WRITE_DONE
		&& (busy_len == NV_WRITE_CYCLES || busy_len == VOL_WRITE_CYCLES);
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("write time");
endmodule
`default_nettype wire

// ### sim/fscr_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// host controller issuing register commands
// ****
module fscr_host (
	input  wire logic       i_clock,
	input  wire logic       i_busy,
	input  wire logic       i_done,
	input  wire logic       i_rvalid,
	input  wire logic [7:0] i_rdata,
	output var  logic       o_valid,
	output var  logic [7:0] o_opcode,
	output var  logic [7:0] o_addr,
	output var  logic [15:0] o_wdata,
	output var  logic       o_two
);
	initial begin
		{o_valid, o_opcode, o_addr, o_wdata, o_two} = 34'h0_0000_0000;
	end
	task cmd(input logic [7:0] o, a, input logic [15:0] d, input logic t);
		@(negedge i_clock);
		o_valid = 1'b1;
		o_opcode = o;
		o_addr = a;
		o_wdata = d;
		o_two = t;
		@(negedge i_clock);
		o_valid = 1'b0;
		// idle address and data lines never keep the last value
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
	task rd(input logic [7:0] o, a, output logic [7:0] q, output logic v);
		cmd(o, a, 16'h0000, 1'b0);
		q = i_rdata;
		v = i_rvalid;
	endtask
	// next write once busy has ended or after 40 cycles of busy
	task wr(input logic [7:0] o, a, input logic [15:0] d, input logic t,
		output int n, output logic dn);
		cmd(o, a, d, t);
		n = 0;
		while (i_busy === 1'b1 && n < 40) begin
			@(negedge i_clock);
			n++;
		end
		dn = i_done;
		@(negedge i_clock);
	endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// register bank testbench
// ****
module tb_top;
	localparam NV_CYC = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic we, esus, psus, vd, vp, qa, qnv, srst, otp, uni, dn;
	wire logic valid, two, busy, done, rv, perr, porg, pvol, ploc, fl, frz;
	wire logic [7:0] op, addr, rdata;
	wire logic [15:0] wdata;
	wire logic [2:0] prot;
	int n;
	int err_total = 0;
	int samples_checked = 0;
	always #25 clk = ~clk;
	fscr_regs #(.NV_WRITE_CYCLES(NV_CYC)) dut_u (.I_CLOCK(clk),
		.I_RESETN(rst_n), .I_CMD_VALID(valid), .I_CMD_OPCODE(op),
		.I_CMD_ADDR(addr), .I_CMD_WDATA(wdata), .I_CMD_TWO_BYTES(two),
		.I_WRITE_ENABLE(we), .I_ERASE_SUSPEND(esus),
		.I_PROGRAM_SUSPEND(psus), .I_VERIFY_DONE(vd), .I_VERIFY_PASS(vp),
		.I_QPI_ACTIVE(qa), .I_QPI_NV_PROGRAMMED(qnv), .I_SOFT_RESET(srst),
		.I_OTP_PROGRAM_REQ(otp), .I_UNIFORM_SECTORS(uni), .O_RDATA(rdata),
		.O_RVALID(rv), .O_BUSY(busy), .O_WRITE_DONE(done),
		.O_PROGRAM_ERROR(perr), .O_PROT_ORIGIN(porg),
		.O_PROT_VOLATILE(pvol), .O_BLOCK_PROTECT(prot),
		.O_PARAM_LOCATION(ploc), .O_FOUR_LANE(fl), .O_FREEZE(frz));
	fscr_host host_u (.i_clock(clk), .i_busy(busy), .i_done(done),
		.i_rvalid(rv), .i_rdata(rdata), .o_valid(valid), .o_opcode(op),
		.o_addr(addr), .o_wdata(wdata), .o_two(two));
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task rdchk(input logic [7:0] o, a, e, input string nm);
		logic [7:0] q;
		logic       v;
		host_u.rd(o, a, q, v);
		chk(v, 1'b1, nm);
		chk(q, e, nm);
	endtask
	task close_out;
		$display("mismatches %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task t_reset;
		rdchk(8'h07, 8'h00, 8'h00, "second reset");
		rdchk(8'h65, 8'h02, 8'h00, "config reset");
		rdchk(8'h65, 8'h40, 8'h00, "unmapped");
	endtask
	task t_susp;
		we = 1'b1;
		esus = 1'b1;
		host_u.wr(8'h71, 8'h11, 16'h00ff, 1'b0, n, dn);
		rdchk(8'h07, 8'h00, 8'h02, "erase susp");
		esus = 1'b0;
		psus = 1'b1;
		rdchk(8'h65, 8'h11, 8'h01, "prog susp");
		psus = 1'b0;
	endtask
	task t_verify;
		for (int i = 1; i >= 0; i--) begin
			@(negedge clk);
			vd = 1'b1;
			vp = i[0];
			@(negedge clk);
			vd = 1'b0;
			rdchk(8'h07, 8'h00, i ? 8'h04 : 8'h00, "erase result");
		end
	endtask
	task t_slow;
		host_u.wr(8'h01, 8'h00, 16'h0014, 1'b0, n, dn);
		chk(n, NV_CYC, "slow busy");
		chk({dn, prot}, 4'b1101, "nv protect");
		we = 1'b0;
		host_u.wr(8'h01, 8'h00, 16'h000c, 1'b0, n, dn);
		chk(prot, 3'b101, "no enable");
		we = 1'b1;
	endtask
	task t_cfg;
		host_u.wr(8'h71, 8'h02, 16'h00f6, 1'b0, n, dn);
		rdchk(8'h65, 8'h02, 8'h26, "config set");
		chk({porg, ploc}, 2'b11, "origin loc");
		host_u.wr(8'h71, 8'h02, 16'h0000, 1'b0, n, dn);
		rdchk(8'h65, 8'h02, 8'h24, "sticky");
		uni = 1'b1;
		repeat (3) @(negedge clk);
		chk(ploc, 1'b0, "uniform");
		uni = 1'b0;
	endtask
	task t_sel;
		host_u.wr(8'h01, 8'h00, 16'h2c00, 1'b1, n, dn);
		chk({pvol, prot}, 4'b1111, "selector");
		host_u.wr(8'h01, 8'h00, 16'h0008, 1'b0, n, dn);
		chk(n, 1, "fast busy");
		chk(prot, 3'b010, "vol protect");
		rdchk(8'h65, 8'h00, 8'h1c, "nv kept");
	endtask
	task t_lane;
		@(negedge clk);
		qnv = 1'b1;
		@(negedge clk);
		qnv = 1'b0;
		rdchk(8'h65, 8'h02, 8'h2e, "lane default");
		qa = 1'b1;
		host_u.wr(8'h71, 8'h02, 16'h0000, 1'b0, n, dn);
		rdchk(8'h65, 8'h02, 8'h2e, "lane hold");
		qa = 1'b0;
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk({fl, prot}, 4'b1111, "soft reload");
	endtask
	task t_frz;
		host_u.wr(8'h71, 8'h12, 16'h0001, 1'b0, n, dn);
		rdchk(8'h65, 8'h02, 8'h2e, "freeze dflt");
		host_u.wr(8'h01, 8'h00, 16'h0000, 1'b0, n, dn);
		chk({frz, prot}, 4'b1111, "frozen");
		@(negedge clk);
		otp = 1'b1;
		@(negedge clk);
		otp = 1'b0;
		chk(perr, 1'b1, "otp fail");
	endtask
	initial begin
		{we, esus, psus, vd, vp, qa, qnv, srst, otp, uni} = 10'h000;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset;
		t_susp;
		t_verify;
		t_slow;
		t_cfg;
		t_sel;
		t_lane;
		t_frz;
		close_out;
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		err_total++;
		close_out;
	end
endmodule
bind fscr_regs fscr_regs_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES),
	.VOL_WRITE_CYCLES(VOL_WRITE_CYCLES)) chk_u (.I_CLOCK(I_CLOCK),
	.I_RESETN(I_RESETN), .I_CMD_VALID(I_CMD_VALID),
	.I_CMD_OPCODE(I_CMD_OPCODE), .I_WRITE_ENABLE(I_WRITE_ENABLE),
	.I_ERASE_SUSPEND(I_ERASE_SUSPEND), .I_PROGRAM_SUSPEND(I_PROGRAM_SUSPEND),
	.I_SOFT_RESET(I_SOFT_RESET), .I_OTP_PROGRAM_REQ(I_OTP_PROGRAM_REQ),
	.I_UNIFORM_SECTORS(I_UNIFORM_SECTORS), .O_RDATA(O_RDATA),
	.O_RVALID(O_RVALID), .O_BUSY(O_BUSY), .O_WRITE_DONE(O_WRITE_DONE),
	.O_PROGRAM_ERROR(O_PROGRAM_ERROR), .O_PROT_ORIGIN(O_PROT_ORIGIN),
	.O_BLOCK_PROTECT(O_BLOCK_PROTECT), .O_PARAM_LOCATION(O_PARAM_LOCATION),
	.O_FREEZE(O_FREEZE));
`default_nettype wire
